// file: verilog/rss_params.svh
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH

// E-clock counts of the reset sequence and the width of their timer
`define RSS_POR_CYCLES 4064
`define RSS_DRIVE_CYCLES 4
`define RSS_SAMPLE_CYCLES 2
`define RSS_TMR_W 12

// Vector addresses, normal mode
`define RSS_VEC_NORM_RST 16'hfffe
`define RSS_VEC_NORM_CM 16'hfffc
`define RSS_VEC_NORM_WD 16'hfffa

// Vector addresses, special test or bootstrap mode
`define RSS_VEC_SPEC_RST 16'hbffe
`define RSS_VEC_SPEC_CM 16'hbffc
`define RSS_VEC_SPEC_WD 16'hbffa

`endif

// file: verilog/rss_pkg.sv
`default_nettype none
package rss_pkg;

  typedef enum logic [5:0] {
    RSS_RUN      = 6'h01,
    RSS_POR_WAIT = 6'h02,
    RSS_DRIVE    = 6'h04,
    RSS_SETTLE   = 6'h08,
    RSS_HOLD_EXT = 6'h10,
    RSS_FETCH    = 6'h20
  } rss_state_t;

  typedef enum logic [1:0] {
    RSS_CAUSE_POR  = 2'h0,
    RSS_CAUSE_EXT  = 2'h1,
    RSS_CAUSE_WDOG = 2'h2,
    RSS_CAUSE_CM   = 2'h3
  } rss_cause_t;

  typedef struct packed {
    logic software_watchdog_timeout;
    logic software_watchdog_enable;
    logic clkmon_fail;
    logic clkmon_enable;
  } rss_src_t;

endpackage
`default_nettype wire

// file: verilog/rss_tick_timer.sv
`timescale 1ns/1ps
`default_nettype none
module rss_tick_timer #(
  parameter int W = 12
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic en_in,
  // Control
  input wire logic start_in,
  input wire logic tick_in,
  input wire logic [W-1:0] limit_in,
  // Status
  output logic done_out
);
  logic [W-1:0] count;
  wire at_limit = (count == limit_in);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count <= '0;
    end else if (en_in) begin
      if (start_in) begin
        count <= '0;
      end else if (tick_in && !at_limit) begin
        count <= count + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign done_out = at_limit;
endmodule
`default_nettype wire

// file: verilog/rss_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "rss_params.svh"

module rss_sequencer import rss_pkg::*; #(
  parameter int POR_CYCLES = `RSS_POR_CYCLES,
  parameter logic [15:0] VEC_NORM_WD = `RSS_VEC_NORM_WD,
  parameter logic [15:0] VEC_SPEC_WD = `RSS_VEC_SPEC_WD
) (
  // Clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  // Timing and mode
  input wire logic e_tick_in,
  input wire logic special_mode_in,
  // Asynchronous levels
  input wire logic supply_good_in,
  input wire logic osc_active_in,
  // Reset pin
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe_n_out,
  // Internal sources
  input wire rss_src_t src_in,
  // Processor side
  output logic cpu_reset_out,
  output logic regs_init_out,
  output logic pc_load_out,
  output logic [15:0] vector_out,
  output rss_cause_t cause_out
);
  rss_state_t st, next_st;
  rss_cause_t cause, next_cause;
  logic [2:0] sync_a, sync_b;
  logic supply_d;
  logic tmr_done;

  // Two stages per pin; stage b is read, and supply_d delays stage b of the supply for its rise edge
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      supply_d <= 1'b0;
    end else if (clk_en_in) begin
      sync_a <= {supply_good_in, osc_active_in, reset_pin_in};
      sync_b <= sync_a;
      supply_d <= sync_b[2];
    end
  end

  wire pin_high = sync_b[0];
  wire osc_ok = sync_b[1];
  wire supply_rise = sync_b[2] && !supply_d;
  wire cm_req = src_in.clkmon_fail && src_in.clkmon_enable;
  wire wd_req = src_in.software_watchdog_timeout && src_in.software_watchdog_enable;
  wire int_req = cm_req || wd_req;
  wire run_event = (st == RSS_RUN) && (int_req || !pin_high);

  wire in_por = (st == RSS_POR_WAIT);
  // A supply rise inside the delay must restart the count as well
  wire tmr_start = (next_st != st) || supply_rise;
  wire tmr_tick = e_tick_in && (!in_por || osc_ok);
  wire [`RSS_TMR_W-1:0] lim_por = POR_CYCLES[`RSS_TMR_W-1:0];
  localparam int DRIVE_CYC = `RSS_DRIVE_CYCLES;
  localparam int SAMPLE_CYC = `RSS_SAMPLE_CYCLES;
  wire [`RSS_TMR_W-1:0] lim_drv = DRIVE_CYC[`RSS_TMR_W-1:0];
  wire [`RSS_TMR_W-1:0] lim_smp = SAMPLE_CYC[`RSS_TMR_W-1:0];
  wire [`RSS_TMR_W-1:0] tmr_limit = in_por ? lim_por :
                                   (st == RSS_DRIVE) ? lim_drv : lim_smp;

  rss_tick_timer #(.W(`RSS_TMR_W)) u_timer (
    .clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .en_in(clk_en_in),
    .start_in(tmr_start),
    .tick_in(tmr_tick),
    .limit_in(tmr_limit),
    .done_out(tmr_done)
  );

  always_comb begin
    next_st = st;
    next_cause = cause;
    case (st)
      RSS_RUN: begin
        if (cm_req) begin
          next_st = RSS_DRIVE;
          next_cause = RSS_CAUSE_CM;
        end else if (wd_req) begin
          next_st = RSS_DRIVE;
          next_cause = RSS_CAUSE_WDOG;
        end else if (!pin_high) begin
          next_st = RSS_DRIVE;
          next_cause = RSS_CAUSE_EXT;
        end
      end
      RSS_POR_WAIT: begin
        if (tmr_done) begin
          next_st = pin_high ? RSS_DRIVE : RSS_HOLD_EXT;
        end
      end
      RSS_DRIVE: begin
        if (tmr_done) begin
          next_st = RSS_SETTLE;
        end
      end
      RSS_SETTLE: begin
        if (tmr_done && !pin_high) begin
          next_st = RSS_HOLD_EXT;
          if (cause != RSS_CAUSE_POR) begin
            next_cause = RSS_CAUSE_EXT;
          end
        end else if (tmr_done) begin
          next_st = RSS_FETCH;
        end
      end
      RSS_HOLD_EXT: begin
        if (pin_high) begin
          next_st = RSS_FETCH;
        end
      end
      RSS_FETCH: begin
        next_st = RSS_RUN;
      end
      default: begin
        next_st = RSS_POR_WAIT;
        next_cause = RSS_CAUSE_POR;
      end
    endcase
    // A fresh supply rise restarts from anywhere
    if (supply_rise) begin
      next_st = RSS_POR_WAIT;
      next_cause = RSS_CAUSE_POR;
    end
  end

  // shared normal vector for power-up and pin
  wire rst_vec = (cause == RSS_CAUSE_POR) || (cause == RSS_CAUSE_EXT);
  wire cm_vec = (cause == RSS_CAUSE_CM);
  wire [15:0] norm_vec = rst_vec ? `RSS_VEC_NORM_RST : cm_vec ? `RSS_VEC_NORM_CM : VEC_NORM_WD;
  wire [15:0] spec_vec = rst_vec ? `RSS_VEC_SPEC_RST : cm_vec ? `RSS_VEC_SPEC_CM : VEC_SPEC_WD;
  wire [15:0] sel_vec = special_mode_in ? spec_vec : norm_vec;
  wire entering = (next_st != RSS_RUN) && ((st == RSS_RUN) || supply_rise);

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= RSS_POR_WAIT;
      cause <= RSS_CAUSE_POR;
      cpu_reset_out <= 1'b1;
      regs_init_out <= 1'b1;
      pc_load_out <= 1'b0;
      vector_out <= `RSS_VEC_NORM_RST;
      cause_out <= RSS_CAUSE_POR;
      reset_pin_out <= 1'b0;
      reset_pin_oe_n_out <= 1'b1;
    end else if (clk_en_in) begin
      st <= next_st;
      cause <= next_cause;
      cpu_reset_out <= (next_st != RSS_RUN);
      regs_init_out <= entering;
      pc_load_out <= (st == RSS_FETCH);
      vector_out <= sel_vec;
      cause_out <= cause;
      reset_pin_out <= 1'b0;
      // drive low only in drive phase
      reset_pin_oe_n_out <= (next_st != RSS_DRIVE);
    end
  end

  // Reset pin timing relies on the outside circuit not slowing the rising edge
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  int unsigned drv_ticks;
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      drv_ticks <= 0;
    end else if (clk_en_in && st != RSS_DRIVE) begin
      drv_ticks <= 0;
    end else if (clk_en_in && e_tick_in && !tmr_done) begin
      drv_ticks <= drv_ticks + 1;
    end
  end

  chk_drive_len: assert property (
    (st == RSS_DRIVE && clk_en_in && next_st == RSS_SETTLE && !supply_rise)
      |-> (drv_ticks == DRIVE_CYC)
  ) else $error("pin drive not four E cycles");
  chk_pin_oe_drive: assert property (
    !reset_pin_oe_n_out |-> (st == RSS_DRIVE && !reset_pin_out)
  ) else $error("pin driven outside drive phase");
  chk_sample_ext: assert property (
    (st == RSS_SETTLE && tmr_done && !pin_high && clk_en_in && !supply_rise)
      |=> (st == RSS_HOLD_EXT && cause != RSS_CAUSE_WDOG && cause != RSS_CAUSE_CM)
  ) else $error("low pin at sample not taken as external");
  chk_vec_shared: assert property (
    (pc_load_out && !$past(special_mode_in) && $past(rst_vec))
      |-> (vector_out == `RSS_VEC_NORM_RST)
  ) else $error("power-up or pin reset vector wrong");
  chk_vec_mode: assert property (
    (pc_load_out && $past(special_mode_in) && $past(cm_vec)) |-> (vector_out == `RSS_VEC_SPEC_CM)
  ) else $error("special mode clock monitor vector wrong");
  chk_wdog_start: assert property (
    (st == RSS_RUN && wd_req && !cm_req && clk_en_in && !supply_rise)
      |=> (st == RSS_DRIVE && cause == RSS_CAUSE_WDOG && cpu_reset_out)
  ) else $error("watchdog did not start reset");
  chk_cm_start: assert property (
    (st == RSS_RUN && cm_req && clk_en_in && !supply_rise) |=> (cause == RSS_CAUSE_CM ##0 regs_init_out)
  ) else $error("clock monitor did not start reset");
  chk_supply_drop: assert property (
    (st == RSS_RUN && $fell(sync_b[2]) && clk_en_in)
      |=> (st != RSS_POR_WAIT && cause != RSS_CAUSE_POR && ($past(run_event) || st == RSS_RUN))
  ) else $error("supply drop raised a reset");
  chk_por_hold: assert property (
    (st == RSS_POR_WAIT) |-> cpu_reset_out
  ) else $error("processor released during power-up delay");
  chk_ext_hold: assert property (
    (st == RSS_HOLD_EXT && !pin_high && !supply_rise) |=> (st == RSS_HOLD_EXT && cpu_reset_out)
  ) else $error("released while pin low");
  chk_fetch_load: assert property (
    (st == RSS_FETCH && clk_en_in) |=> (pc_load_out && !cpu_reset_out)
  ) else $error("vector not loaded on release");

  cov_wdog_seq: cover property (pc_load_out && cause_out == RSS_CAUSE_WDOG);
  cov_cm_seq: cover property (pc_load_out && cause_out == RSS_CAUSE_CM);
  cov_ext_seq: cover property (pc_load_out && cause_out == RSS_CAUSE_EXT);
  cov_por_hold: cover property (st == RSS_POR_WAIT ##1 st == RSS_HOLD_EXT);
endmodule
`default_nettype wire

// file: tb/rss_supervisor_model.sv
`timescale 1ns/1ps
`default_nettype none
module rss_supervisor_model (
  // Supply and command
  input wire logic supply_good_in,
  input wire logic ext_hold_in,
  // Device side of the pin
  input wire logic dev_pin_in,
  input wire logic dev_oe_n_in,
  // Resolved pin level
  output logic pin_out
);
  // low under bad supply
  // Pull-up wins when nobody pulls; release is a clean edge, no slow RC
  assign pin_out = !((!dev_oe_n_in && !dev_pin_in) || !supply_good_in || ext_hold_in);
endmodule
`default_nettype wire

// file: tb/reset_source_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "rss_params.svh"
module reset_source_sequencer_bench import rss_pkg::*; ;
  localparam int POR_CYC = 8;
  logic sys_clk = 1'b0;
  logic e_tick = 1'b0;
  logic rstn, clk_en, special_mode, supply_good, osc_active, ext_hold;
  rss_src_t src;
  logic pin_drv, oe_n, cpu_reset, regs_init, pc_load;
  logic [15:0] vector;
  rss_cause_t cause;
  wire logic pin;
  int n_fail, cmp_count;

  rss_supervisor_model partner (.supply_good_in(supply_good), .ext_hold_in(ext_hold),
    .dev_pin_in(pin_drv), .dev_oe_n_in(oe_n), .pin_out(pin));

  rss_sequencer #(.POR_CYCLES(POR_CYC)) uut (.sys_clk_in(sys_clk), .rstn_in(rstn),
    .clk_en_in(clk_en), .e_tick_in(e_tick), .special_mode_in(special_mode),
    .supply_good_in(supply_good), .osc_active_in(osc_active), .reset_pin_in(pin),
    .reset_pin_out(pin_drv), .reset_pin_oe_n_out(oe_n), .src_in(src),
    .cpu_reset_out(cpu_reset), .regs_init_out(regs_init), .pc_load_out(pc_load),
    .vector_out(vector), .cause_out(cause));

  always #2 sys_clk = ~sys_clk;
  // Tick every other cycle so the E-clock counts differ from clock counts
  always @(posedge sys_clk) e_tick <= ~e_tick;

  task automatic check(input bit ok, input string msg);
    cmp_count++;
    if (!ok) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic wait_fetch(input logic [15:0] vec, input rss_cause_t cs, input int lo,
                            input int hi, input int inits, output int cyc);
    int oe;
    int ini;
    bit seen;
    oe = 0;
    ini = 0;
    seen = 0;
    for (cyc = 0; cyc < 400 && !seen; cyc++) begin
      @(negedge sys_clk);
      if (oe_n === 1'b0) oe++;
      if (regs_init === 1'b1) ini++;
      if (pc_load === 1'b1) seen = 1;
    end
    check(seen, "no vector load");
    check(vector === vec, "wrong vector");
    check(cause === cs, "wrong cause");
    check(cpu_reset === 1'b0, "processor still held at vector load");
    check(oe >= lo && oe <= hi, "pin drive length");
    if (inits >= 0) check(ini == inits, "init pulse count");
  endtask

  task automatic test_power_up;
    int cyc;
    @(posedge sys_clk);
    supply_good <= 1'b1;
    ext_hold <= 1'b1;
    fork
      begin
        repeat (20) @(posedge sys_clk);
        osc_active <= 1'b1;
        repeat (60) @(posedge sys_clk);
        ext_hold <= 1'b0;
      end
      wait_fetch(`RSS_VEC_NORM_RST, RSS_CAUSE_POR, 0, 0, -1, cyc);
    join
    check(cyc >= 80, "left reset while pin low");
    $display("power-up test done");
  endtask

  task automatic test_internal;
    int cyc;
    logic [15:0] vec;
    for (int i = 0; i < 4; i++) begin
      repeat (4) @(posedge sys_clk);
      special_mode <= i[1];
      src <= i[0] ? rss_src_t'(4'h3) : rss_src_t'(4'hc);
      if (i[1]) vec = i[0] ? `RSS_VEC_SPEC_CM : `RSS_VEC_SPEC_WD;
      else vec = i[0] ? `RSS_VEC_NORM_CM : `RSS_VEC_NORM_WD;
      // Watch from the request on so the entry pulse is not missed
      fork
        begin
          repeat (2) @(posedge sys_clk);
          src <= rss_src_t'(4'h0);
        end
        wait_fetch(vec, i[0] ? RSS_CAUSE_CM : RSS_CAUSE_WDOG, 7, 10, 1, cyc);
      join
    end
    @(posedge sys_clk);
    special_mode <= 1'b0;
    $display("internal source test done");
  endtask

  // Pass 0: pin pulled from outside; pass 1: watchdog start, pin still low at sample
  task automatic test_external;
    int cyc;
    for (int i = 0; i < 2; i++) begin
      repeat (4) @(posedge sys_clk);
      if (i == 0) ext_hold <= 1'b1;
      else src <= rss_src_t'(4'hc);
      fork
        begin
          repeat (2) @(posedge sys_clk);
          src <= rss_src_t'(4'h0);
          ext_hold <= 1'b1;
          repeat (28) @(posedge sys_clk);
          ext_hold <= 1'b0;
        end
        wait_fetch(`RSS_VEC_NORM_RST, RSS_CAUSE_EXT, 7, 10, 1, cyc);
      join
    end
    $display("external reset test done");
  endtask

  // A drop only pulls the pin; the return of supply restarts the power-up delay
  task automatic test_supply_drop;
    int cyc;
    repeat (4) @(posedge sys_clk);
    supply_good <= 1'b0;
    fork
      begin
        repeat (25) @(posedge sys_clk);
        supply_good <= 1'b1;
      end
      wait_fetch(`RSS_VEC_NORM_RST, RSS_CAUSE_POR, 16, 18, 2, cyc);
    join
    check(cyc >= 25 + 2 * POR_CYC, "vector fetched before power-up delay");
    $display("supply drop test done");
  endtask

  task automatic test_cold_delay;
    int cyc;
    int pre;
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    // Freeze ten cycles; the delay before the pin drive must stretch by as many
    clk_en <= 1'b0;
    fork
      begin
        repeat (10) @(posedge sys_clk);
        clk_en <= 1'b1;
      end
      for (pre = 0; pre < 400 && oe_n !== 1'b0; pre++) @(negedge sys_clk);
      wait_fetch(`RSS_VEC_NORM_RST, RSS_CAUSE_POR, 7, 10, -1, cyc);
    join
    check(cyc >= 2 * POR_CYC, "power-up delay too short");
    check(pre >= 2 * POR_CYC + 10 && pre <= 2 * POR_CYC + 20, "delay or freeze length");
    $display("second cold start test done");
  endtask

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    clk_en = 1'b1;
    special_mode = 1'b0;
    supply_good = 1'b0;
    osc_active = 1'b0;
    ext_hold = 1'b0;
    src = rss_src_t'(4'h0);
    n_fail = 0;
    cmp_count = 0;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    test_power_up;
    test_internal;
    test_external;
    test_supply_drop;
    test_cold_delay;
    give_verdict;
  end

  // The tests need well under a thousand cycles; five thousand means a hang
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    $display("unexpected at %0t: run did not finish", $time);
    give_verdict;
  end
endmodule
`default_nettype wire
